// >>> hw/ipsc_map.svh
// Constants for the idle and operating-point controller.
`ifndef IPSC_MAP_SVH
`define IPSC_MAP_SVH
`define IPSC_CST_C0 3'h0
`define IPSC_CST_C1 3'h1
`define IPSC_CST_C3 3'h3
`define IPSC_CST_C6 3'h6
`define IPSC_CST_C7 3'h7
`define IPSC_RATIO_W 8
`define IPSC_VID_W 8
`define IPSC_RATIO_RST 8'h08
`define IPSC_VID_OFS 8'h10
`define IPSC_VID_HALF 4'h2
`define IPSC_LVL2_OFS 16'h0004
`define IPSC_LVL_BIAS 16'h0002
`define IPSC_LVL_C3 16'h0002
`define IPSC_LVL_C6 16'h0003
`endif

// >>> hw/ipsc_pkg.sv
// Types shared by the idle and operating-point controller.
`include "ipsc_map.svh"
package ipsc_pkg;
  typedef logic [2:0] ipsc_cst_t;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b000,
    PS_VUP = 3'b001,
    PS_LOCKUP = 3'b010,
    PS_LOCKDN = 3'b011,
    PS_VDN = 3'b100
  } ipsc_pst_e;
  typedef enum logic [1:0] {
    VT_IDLE = 2'b00,
    VT_SHIFT = 2'b01,
    VT_WAIT = 2'b10
  } ipsc_vtx_e;
endpackage

// >>> hw/ipsc_vid_if.sv
// Handshake between the controller and the voltage-ID bus sender.
`timescale 1ns/100ps
`default_nettype none
interface ipsc_vid_if #(parameter int VW = 8);
  logic start;
  logic [VW-1:0] code;
  logic done;
  modport ctl (output start, output code, input done);
  modport phy (input start, input code, output done);
endinterface
`default_nettype wire

// >>> hw/ipsc_vid_tx.sv
// Serial sender of voltage targets to the external regulator.
`timescale 1ns/100ps
`default_nettype none
`include "ipsc_map.svh"
module ipsc_vid_tx
  import ipsc_pkg::*;
#(
  parameter int VW = `IPSC_VID_W
) (
  // Clock, reset and enable
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Controller side
  ipsc_vid_if.phy vif,
  // Regulator pins
  output logic vid_clk_o,
  output logic vid_data_o,
  input wire logic vr_ack_pin_i
);
  typedef struct packed {
    ipsc_vtx_e vt;
    logic [7:0] bits;
    logic [3:0] half;
    logic [VW-1:0] sh;
    logic sclk;
    logic sdat;
    logic done;
    logic [2:0] ack_sync;
    logic ack;
  } ipsc_vtx_s;
  ipsc_vtx_s st;
  ipsc_vtx_s nx;

  if (VW < 1 || VW > 255) begin : g_chk
    $error("Voltage code width out of range.");
  end

  always_comb begin
    nx = st;
    nx.done = 1'b0;
    nx.ack_sync = {st.ack_sync[1:0], vr_ack_pin_i};
    if (st.ack_sync[1] == st.ack_sync[2]) begin
      nx.ack = st.ack_sync[2];
    end
    case (st.vt)
      VT_IDLE: begin
        if (vif.start) begin
          nx.vt = VT_SHIFT;
          nx.sh = vif.code;
          nx.bits = 8'(VW);
          nx.half = 4'h0;
          nx.sclk = 1'b0;
          nx.sdat = vif.code[VW-1];
        end
      end
      VT_SHIFT: begin
        nx.half = st.half + 4'h1;
        if (st.half == `IPSC_VID_HALF - 4'h1) begin
          nx.half = 4'h0;
          nx.sclk = ~st.sclk;
          if (st.sclk) begin
            nx.sh = st.sh << 1;
            nx.sdat = nx.sh[VW-1];
            nx.bits = st.bits - 8'h01;
            if (st.bits == 8'h01) begin
              nx.vt = VT_WAIT;
              nx.sdat = 1'b0;
            end
          end
        end
      end
      VT_WAIT: begin
        if (st.ack_sync[1] == st.ack_sync[2] && st.ack_sync[2] != st.ack) begin
          nx.done = 1'b1;
          nx.vt = VT_IDLE;
        end
      end
      default: nx.vt = VT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= nx;
    end
  end

  assign vif.done = st.done;
  assign vid_clk_o = st.sclk;
  assign vid_data_o = st.sdat;
endmodule
`default_nettype wire

// >>> hw/ipsc_top.sv
// Idle-state and operating-point controller for a multi-core processor.
`timescale 1ns/100ps
`default_nettype none
`include "ipsc_map.svh"
module ipsc_top
  import ipsc_pkg::*;
#(
  parameter int NUM_CORES = 2,
  parameter int RW = `IPSC_RATIO_W,
  parameter int VW = `IPSC_VID_W
) (
  // Clock, reset and enable
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Operating-point requests and PLL
  input wire logic [NUM_CORES-1:0] pst_req_i,
  input wire logic [NUM_CORES*RW-1:0] pst_ratio_i,
  input wire logic pll_lock_pin_i,
  output logic pll_req_o,
  output logic [RW-1:0] pll_ratio_o,
  output logic [RW-1:0] cur_ratio_o,
  output logic pst_busy_o,
  // Voltage-ID bus
  output logic vid_clk_o,
  output logic vid_data_o,
  input wire logic vr_ack_pin_i,
  // Thread idle requests and wake events
  input wire logic [2*NUM_CORES-1:0] idle_req_i,
  input wire logic [2*NUM_CORES*3-1:0] idle_cst_i,
  input wire logic [2*NUM_CORES-1:0] idle_monitor_wait_instruction_i,
  input wire logic [2*NUM_CORES-1:0] idle_deep_i,
  input wire logic [2*NUM_CORES-1:0] irq_i,
  input wire logic [2*NUM_CORES-1:0] intr_en_flag_i,
  input wire logic [2*NUM_CORES-1:0] mon_hit_i,
  // Legacy idle-level reads
  input wire logic io_rd_i,
  input wire logic [$clog2(2*NUM_CORES)-1:0] io_thr_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [15:0] ctl_blk_base_i,
  input wire logic [7:0] io_cap_range_i,
  input wire logic redirect_en_i,
  output logic io_pass_o,
  // Configuration
  input wire logic c1e_en_i,
  // Core power actions
  input wire logic [NUM_CORES-1:0] save_done_i,
  output logic [NUM_CORES*3-1:0] core_cst_o,
  output logic c1e_o,
  output logic [NUM_CORES-1:0] core_flush_o,
  output logic [NUM_CORES-1:0] core_clk_stop_o,
  output logic [NUM_CORES-1:0] core_save_o,
  output logic [NUM_CORES-1:0] core_pwr_off_o,
  output logic [NUM_CORES-1:0] core_restore_o,
  output logic [NUM_CORES-1:0] core_snoop_en_o,
  output logic [NUM_CORES-1:0] l3_flush_o,
  output logic [NUM_CORES-1:0] l3_flush_all_o
);
  localparam int NT = 2 * NUM_CORES;
  localparam int TW = $clog2(NT);
  typedef struct packed {
    ipsc_pst_e pst;
    logic busy;
    logic [RW-1:0] cur_ratio;
    logic [RW-1:0] tgt_ratio;
    logic [NUM_CORES-1:0][RW-1:0] core_req;
    logic vid_start;
    logic [VW-1:0] vid_code;
    logic pll_req;
    logic [2:0] lk_sync;
    logic lk;
    logic [NT-1:0][2:0] thr;
    logic [NT-1:0] thr_mw;
    logic [NT-1:0] thr_brk;
    logic [NT-1:0] thr_deep;
    logic [NUM_CORES-1:0][2:0] core_prev;
    logic [NUM_CORES-1:0] flush;
    logic [NUM_CORES-1:0] clkstop;
    logic [NUM_CORES-1:0] save;
    logic [NUM_CORES-1:0] pwroff;
    logic [NUM_CORES-1:0] restore;
    logic [NUM_CORES-1:0] snoop_en;
    logic [NUM_CORES-1:0] l3f;
    logic [NUM_CORES-1:0] l3all;
    logic c1e;
    logic io_pass;
  } ipsc_st_s;
  ipsc_st_s st, nx;
  logic [NUM_CORES-1:0][2:0] core_res;
  logic [NUM_CORES-1:0] core_deep;
  logic [NT-1:0] wake;
  logic all_c1, all_c7, prev_c7;
  logic io_hit;
  logic [15:0] io_ofs, io_lvl;
  ipsc_cst_t io_cst;
  logic [RW-1:0] best;
  logic any_act;
  ipsc_vid_if #(.VW(VW)) vif ();
  if (NUM_CORES < 1 || RW < 1 || VW < RW) begin : g_chk
    $error("Unsupported core count or code width.");
  end
  ipsc_vid_tx #(.VW(VW)) u_vid (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .vif(vif.phy),
    .vid_clk_o(vid_clk_o),
    .vid_data_o(vid_data_o),
    .vr_ack_pin_i(vr_ack_pin_i)
  );
  for (genvar t = 0; t < NT; t++) begin : g_thr
    assign wake[t] = (irq_i[t] && (intr_en_flag_i[t] || st.thr_brk[t]))
      || (mon_hit_i[t] && st.thr_mw[t]);
    a_via_c0: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      ($past(st.thr[t]) != `IPSC_CST_C0 && $changed(st.thr[t]))
      |-> st.thr[t] == `IPSC_CST_C0) else $error("Idle skip C0.");
    a_wake_thread: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      (st.thr[t] != `IPSC_CST_C0 && irq_i[t] && intr_en_flag_i[t] && ce_i)
      |=> st.thr[t] == `IPSC_CST_C0) else $error("No wake.");
  end
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    assign core_res[c] = (st.thr[2*c] < st.thr[2*c+1]) ?
      st.thr[2*c] : st.thr[2*c+1];
    assign core_deep[c] = st.thr_deep[2*c] | st.thr_deep[2*c+1];
    a_core_min: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      $past(ce_i) |-> st.core_prev[c] == $past(core_res[c]))
      else $error("Core state not the lowest thread.");
    a_c3_order: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      $rose(st.clkstop[c]) |-> $past(st.flush[c]))
      else $error("Clocks stopped before flush.");
    a_c6_save: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      $rose(st.pwroff[c]) |-> $past(save_done_i[c]) && st.core_prev[c] >= 3'h6)
      else $error("Power off before save.");
    a_l3_last: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      st.l3f[c] |-> $past(all_c7) && !$past(prev_c7))
      else $error("Cache flush not by last core.");
  end
  always_comb begin
    all_c1 = 1'b1;
    all_c7 = 1'b1;
    prev_c7 = 1'b1;
    best = st.cur_ratio;
    any_act = 1'b0;
    for (int c = 0; c < NUM_CORES; c++) begin
      all_c1 = all_c1 && (core_res[c] >= `IPSC_CST_C1);
      all_c7 = all_c7 && (core_res[c] == `IPSC_CST_C7);
      prev_c7 = prev_c7 && (st.core_prev[c] == `IPSC_CST_C7);
      if (core_res[c] == `IPSC_CST_C0 &&
          (!any_act || st.core_req[c] > best)) begin
        best = st.core_req[c];
        any_act = 1'b1;
      end
    end
  end

  always_comb begin
    nx = st;
    nx.vid_start = 1'b0;
    io_ofs = io_addr_i - ctl_blk_base_i;
    io_lvl = io_ofs - `IPSC_LVL_BIAS;
    io_hit = io_rd_i && redirect_en_i && (io_ofs >= `IPSC_LVL2_OFS)
      && (io_lvl <= {8'h00, io_cap_range_i});
    io_cst = (io_lvl == `IPSC_LVL_C3) ? `IPSC_CST_C3 :
      (io_lvl == `IPSC_LVL_C6) ? `IPSC_CST_C6 : `IPSC_CST_C7;
    nx.io_pass = io_rd_i && !io_hit;
    nx.lk_sync = {st.lk_sync[1:0], pll_lock_pin_i};
    if (st.lk_sync[1] == st.lk_sync[2]) begin
      nx.lk = st.lk_sync[2];
    end
    for (int t = 0; t < NT; t++) begin
      if (st.thr[t] != `IPSC_CST_C0) begin
        if (wake[t]) begin
          nx.thr[t] = `IPSC_CST_C0;
          nx.thr_brk[t] = 1'b0;
          nx.thr_deep[t] = 1'b0;
        end
      end else if (io_hit && io_thr_i == TW'(t)) begin
        nx.thr[t] = io_cst;
        nx.thr_mw[t] = 1'b1;
        nx.thr_brk[t] = 1'b1;
        nx.thr_deep[t] = 1'b0;
      end else if (idle_req_i[t]) begin
        nx.thr[t] = idle_cst_i[t*3 +: 3];
        nx.thr_mw[t] = idle_monitor_wait_instruction_i[t];
        nx.thr_brk[t] = 1'b0;
        nx.thr_deep[t] = idle_deep_i[t]
          && idle_cst_i[t*3 +: 3] == `IPSC_CST_C7;
      end
    end
    for (int c = 0; c < NUM_CORES; c++) begin
      if (pst_req_i[c]) begin
        nx.core_req[c] = pst_ratio_i[c*RW +: RW];
      end
      nx.core_prev[c] = core_res[c];
      nx.snoop_en[c] = core_res[c] <= `IPSC_CST_C1;
      nx.flush[c] = core_res[c] >= `IPSC_CST_C3
        && st.core_prev[c] < `IPSC_CST_C3;
      nx.clkstop[c] = core_res[c] >= `IPSC_CST_C3
        && (st.clkstop[c] || st.flush[c]);
      nx.save[c] = core_res[c] >= `IPSC_CST_C6
        && st.core_prev[c] < `IPSC_CST_C6;
      nx.pwroff[c] = core_res[c] >= `IPSC_CST_C6
        && (st.pwroff[c] || save_done_i[c]);
      nx.restore[c] = st.pwroff[c] && core_res[c] < `IPSC_CST_C6;
      nx.l3f[c] = all_c7 && !prev_c7
        && st.core_prev[c] != `IPSC_CST_C7;
      nx.l3all[c] = nx.l3f[c] && core_deep[c];
    end
    nx.c1e = c1e_en_i && all_c1;
    case (st.pst)
      PS_IDLE: begin
        if (best > st.cur_ratio) begin
          nx.tgt_ratio = best;
          nx.vid_start = 1'b1;
          nx.vid_code = VW'(best) + `IPSC_VID_OFS;
          nx.pst = PS_VUP;
        end else if (best < st.cur_ratio) begin
          nx.tgt_ratio = best;
          nx.pst = PS_LOCKDN;
        end
      end
      PS_VUP: begin
        if (vif.done) begin
          nx.pst = PS_LOCKUP;
        end
      end
      PS_LOCKUP, PS_LOCKDN: begin
        if (!st.pll_req && !st.lk) begin
          nx.pll_req = 1'b1;
        end else if (st.pll_req && st.lk) begin
          nx.pll_req = 1'b0;
          nx.cur_ratio = st.tgt_ratio;
          nx.pst = PS_IDLE;
          if (st.pst == PS_LOCKDN) begin
            nx.vid_start = 1'b1;
            nx.vid_code = VW'(st.tgt_ratio) + `IPSC_VID_OFS;
            nx.pst = PS_VDN;
          end
        end
      end
      PS_VDN: begin
        if (vif.done) begin
          nx.pst = PS_IDLE;
        end
      end
      default: nx.pst = PS_IDLE;
    endcase
    nx.busy = nx.pst != PS_IDLE;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.cur_ratio <= RW'(`IPSC_RATIO_RST);
      st.tgt_ratio <= RW'(`IPSC_RATIO_RST);
      st.core_req <= {NUM_CORES{RW'(`IPSC_RATIO_RST)}};
      st.snoop_en <= '1;
    end else if (ce_i) begin
      st <= nx;
    end
  end
  assign vif.start = st.vid_start;
  assign vif.code = st.vid_code;
  assign pll_req_o = st.pll_req;
  assign pll_ratio_o = st.tgt_ratio;
  assign cur_ratio_o = st.cur_ratio;
  assign pst_busy_o = st.busy;
  assign io_pass_o = st.io_pass;
  assign core_cst_o = st.core_prev;
  assign c1e_o = st.c1e;
  assign core_flush_o = st.flush;
  assign core_clk_stop_o = st.clkstop;
  assign core_save_o = st.save;
  assign core_pwr_off_o = st.pwroff;
  assign core_restore_o = st.restore;
  assign core_snoop_en_o = st.snoop_en;
  assign l3_flush_o = st.l3f;
  assign l3_flush_all_o = st.l3all;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_vup_no_lock: assert property (st.pst == PS_VUP |-> !st.pll_req)
    else $error("PLL locked before voltage raised.");
  a_up_dir: assert property ((st.pst == PS_IDLE ##1 st.pst == PS_VUP)
    |-> st.tgt_ratio > st.cur_ratio && st.vid_start)
    else $error("Voltage raise on a slower target.");
  a_dn_lock_first: assert property ((st.pst == PS_IDLE ##1
    st.pst == PS_LOCKDN) |-> st.tgt_ratio < st.cur_ratio && !st.vid_start)
    else $error("Voltage lowered before PLL lock.");
  a_freq_shared: assert property ($changed(st.cur_ratio)
    |-> st.cur_ratio == $past(st.tgt_ratio))
    else $error("Frequency moved off the target.");
  a_defer_new: assert property ((st.pst != PS_IDLE && ce_i)
    |=> $stable(st.tgt_ratio))
    else $error("Target changed mid transition.");
  a_c1e_all: assert property (st.c1e |-> $past(c1e_en_i) && $past(all_c1))
    else $error("C1E reported while a core is active.");
  a_redir_quiet: assert property ((io_hit && ce_i) |=> !st.io_pass)
    else $error("Redirected read made an I/O cycle.");
  a_redir_map: assert property ((io_hit && ce_i && io_lvl == `IPSC_LVL_C3
    && st.thr[io_thr_i] == `IPSC_CST_C0)
    |=> st.thr[$past(io_thr_i)] == `IPSC_CST_C3
    && st.thr_brk[$past(io_thr_i)] && !st.thr_deep[$past(io_thr_i)])
    else $error("Level two read not mapped to C3.");
endmodule
`default_nettype wire

// >>> verification/ipsc_vr_model.sv
// Behavioural regulator and PLL on the far side of the controller.
`timescale 1ns/100ps
`default_nettype none
module ipsc_vr_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Serial target, PLL request and answer delay
  input wire logic vid_clk_i,
  input wire logic vid_data_i,
  input wire logic pll_req_i,
  input wire logic [3:0] dly_i,
  // Answers and observation
  output logic vr_ack_o,
  output logic pll_lock_o,
  output logic [7:0] code_o,
  output logic [7:0] frames_o
);
  logic [7:0] sh;
  logic [7:0] seen;
  logic [3:0] nb, cnt, lcnt;
  // Takes one code, MSB first, on rising serial clock edges.
  always @(posedge vid_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nb = 4'h0;
      frames_o <= 8'h00;
      code_o <= 8'h00;
    end else begin
      sh = {sh[6:0], vid_data_i};
      nb = nb + 4'h1;
      if (nb == 4'h8) begin
        nb = 4'h0;
        code_o <= sh;
        frames_o <= frames_o + 8'h01;
      end
    end
  end
  // Toggles the acknowledge only once the voltage has settled.
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vr_ack_o <= 1'b0;
      seen <= 8'h00;
      cnt <= 4'h0;
      pll_lock_o <= 1'b0;
      lcnt <= 4'h0;
    end else begin
      if (seen != frames_o) begin
        if (cnt == dly_i) begin
          vr_ack_o <= ~vr_ack_o;
          seen <= frames_o;
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
      if (pll_req_i !== pll_lock_o) begin
        if (lcnt == dly_i) begin
          pll_lock_o <= pll_req_i;
          lcnt <= 4'h0;
        end else begin
          lcnt <= lcnt + 4'h1;
        end
      end else begin
        lcnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/test_ipsc_top.sv
// Self-checking bench for the idle and operating-point controller.
`timescale 1ns/100ps
`default_nettype none
`include "ipsc_map.svh"
module test_ipsc_top;
  import ipsc_pkg::*;
  logic clk, rst_n, ce, lock, preqo, busy, vclk, vdat, ack;
  logic io_rd, redir, pass, c1e_en, c1e;
  logic [1:0] preq, io_thr, sdone, cstop, poff, snoop, l3f, l3a, l3s, l3as;
  logic [1:0] fl, sv, rs, fls, svs, rss;
  logic [15:0] pratio, io_addr, base;
  logic [7:0] cur, cur_d, rng, code, frames, fc_pll, fc, r, pllr;
  logic [3:0] ireq, mw, deep, irq, flg, mon, dly;
  logic [11:0] icst;
  logic [5:0] ccst;
  logic pr_d;
  logic [7:0] exp_q[$];
  int error_cnt, cmp_count, pass_q, i;
  ipsc_top #(.NUM_CORES(2)) ipsc_top_inst (
    .core_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce), .pst_req_i(preq),
    .pst_ratio_i(pratio), .pll_lock_pin_i(lock), .pll_req_o(preqo),
    .pll_ratio_o(pllr), .cur_ratio_o(cur), .pst_busy_o(busy),
    .vid_clk_o(vclk), .vid_data_o(vdat), .vr_ack_pin_i(ack),
    .idle_req_i(ireq), .idle_cst_i(icst), .idle_monitor_wait_instruction_i(mw),
    .idle_deep_i(deep), .irq_i(irq), .intr_en_flag_i(flg), .mon_hit_i(mon),
    .io_rd_i(io_rd), .io_thr_i(io_thr), .io_addr_i(io_addr),
    .ctl_blk_base_i(base), .io_cap_range_i(rng), .redirect_en_i(redir),
    .io_pass_o(pass), .c1e_en_i(c1e_en), .save_done_i(sdone),
    .core_cst_o(ccst), .c1e_o(c1e), .core_flush_o(fl),
    .core_clk_stop_o(cstop), .core_save_o(sv), .core_pwr_off_o(poff),
    .core_restore_o(rs), .core_snoop_en_o(snoop), .l3_flush_o(l3f),
    .l3_flush_all_o(l3a));
  ipsc_vr_model ipsc_vr_model_inst (
    .core_clk_i(clk), .arst_n_i(rst_n), .vid_clk_i(vclk), .vid_data_i(vdat),
    .pll_req_i(preqo), .dly_i(dly), .vr_ack_o(ack), .pll_lock_o(lock),
    .code_o(code), .frames_o(frames));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task preq_t(input int c, input logic [7:0] rt);
    @(posedge clk);
    pratio[c*8+:8] <= rt;
    preq[c] <= 1'b1;
    @(posedge clk);
    preq[c] <= 1'b0;
  endtask
  task idle_t(input int t, input logic [2:0] s, input logic d);
    @(posedge clk);
    ireq[t] <= 1'b1;
    icst[t*3+:3] <= s;
    mw[t] <= 1'b1;
    deep[t] <= d;
    @(posedge clk);
    ireq[t] <= 1'b0;
  endtask
  task wake_t(input int t, input logic f, input logic m);
    @(posedge clk);
    irq[t] <= !m;
    mon[t] <= m;
    flg[t] <= f;
    tick(2);
    irq[t] <= 1'b0;
    mon[t] <= 1'b0;
  endtask
  task io_t(input int t, input int lvl, input logic p);
    @(posedge clk);
    io_rd <= 1'b1;
    io_thr <= 2'(t);
    io_addr <= base + 16'(lvl + 2);
    if (p) pass_q++;
    @(posedge clk);
    io_rd <= 1'b0;
  endtask
  task wait_done(input logic [7:0] e);
    for (i = 0; i < 800 && !(cur === e && busy === 1'b0); i++) tick(1);
    chk("settle", 8'(i < 800), 8'h01);
  endtask
  // Notes the PLL request moment and compares each completed result.
  always @(posedge clk) begin
    cur_d <= cur;
    pr_d <= preqo;
    l3s <= rst_n ? (l3s | l3f) : 2'b00;
    l3as <= rst_n ? (l3as | l3a) : 2'b00;
    fls <= rst_n ? (fls | fl) : 2'b00;
    svs <= rst_n ? (svs | sv) : 2'b00;
    rss <= rst_n ? (rss | rs) : 2'b00;
    if (preqo === 1'b1 && pr_d === 1'b0) fc_pll <= frames;
    if (rst_n && cur !== cur_d) begin
      if (exp_q.size() == 0) chk("ratio", cur, 8'hff);
      else chk("ratio", cur, exp_q.pop_front());
    end
    if (pass === 1'b1) begin
      chk("io pass", 8'(pass_q > 0), 8'h01);
      pass_q--;
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    error_cnt++;
    close_out();
  end
  initial begin
    {rst_n, io_rd, redir, c1e_en, preq, pratio, io_thr} = '0;
    {sdone, ireq, mw, deep, irq, flg, mon, icst, rng} = '0;
    io_addr = 16'h0000;
    base = 16'h0400;
    dly = 4'h2;
    ce = 1'b1;
    void'($urandom(12447));
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    chk("reset ratio", cur, 8'h08);
    chk("reset snoop", 8'(snoop), 8'h03);
    chk("reset state", 8'(ccst), 8'h00);
    r = 8'h20 + 8'($urandom % 16);
    fc = frames;
    exp_q.push_back(8'h0c);
    exp_q.push_back(r);
    preq_t(1, 8'h0c);
    preq_t(0, r);
    wait_done(r);
    chk("up frames", frames, fc + 8'h02);
    chk("up code", code, r + 8'h10);
    chk("up pll order", fc_pll, fc + 8'h02);
    chk("pll ratio", pllr, r);
    dly <= 4'h9;
    fc = frames;
    exp_q.push_back(8'h0c);
    preq_t(0, 8'h0a);
    wait_done(8'h0c);
    chk("down pll order", fc_pll, fc);
    chk("down frames", frames, fc + 8'h01);
    chk("down code", code, 8'h1c);
    c1e_en <= 1'b1;
    idle_t(0, `IPSC_CST_C1, 1'b0);
    idle_t(1, `IPSC_CST_C3, 1'b0);
    tick(2);
    chk("core0 c1", 8'(ccst[2:0]), 8'(`IPSC_CST_C1));
    chk("c1 snoop", 8'(snoop[0]), 8'h01);
    idle_t(0, `IPSC_CST_C3, 1'b0);
    tick(2);
    chk("no idle hop", 8'(ccst[2:0]), 8'(`IPSC_CST_C1));
    idle_t(2, `IPSC_CST_C1, 1'b0);
    idle_t(3, `IPSC_CST_C7, 1'b0);
    tick(2);
    chk("core1 c1", 8'(ccst[5:3]), 8'(`IPSC_CST_C1));
    chk("c1e", 8'(c1e), 8'h01);
    preq_t(1, 8'h40);
    tick(8);
    chk("idle core ignored", 8'(busy), 8'h00);
    exp_q.push_back(8'h0a);
    wake_t(0, 1'b1, 1'b0);
    tick(2);
    chk("one wake c0", 8'(ccst[2:0]), 8'(`IPSC_CST_C0));
    chk("c1e off", 8'(c1e), 8'h00);
    wake_t(1, 1'b1, 1'b0);
    exp_q.push_back(8'h40);
    wake_t(2, 1'b0, 1'b1);
    wake_t(3, 1'b0, 1'b1);
    wait_done(8'h40);
    chk("mon wake", 8'(ccst[5:3]), 8'(`IPSC_CST_C0));
    redir <= 1'b1;
    rng <= 8'h05;
    for (int lv = 2; lv <= 5; lv++) begin
      io_t(0, lv, 1'b0);
      io_t(1, lv, 1'b0);
      tick(2);
      r = (lv == 2) ? 8'h03 : (lv == 3) ? 8'h06 : 8'h07;
      chk("level map", 8'(ccst[2:0]), r);
      if (lv == 2) begin
        tick(3);
        chk("c3 clk stop", 8'(cstop[0]), 8'h01);
        chk("c3 snoop", 8'(snoop[0]), 8'h00);
      end else begin
        sdone[0] <= 1'b1;
        tick(2);
        chk("power off", 8'(poff[0]), 8'h01);
        sdone[0] <= 1'b0;
      end
      wake_t(0, 1'b0, 1'b0);
      wake_t(1, 1'b0, 1'b0);
      tick(3);
      chk("masked wake", 8'(ccst[2:0]), 8'(`IPSC_CST_C0));
    end
    chk("no early l3", 8'(l3s), 8'h00);
    chk("flush seen", 8'(fls), 8'h01);
    chk("save seen", 8'(svs), 8'h01);
    chk("restore seen", 8'(rss), 8'h01);
    io_t(0, 4, 1'b0);
    io_t(1, 4, 1'b0);
    idle_t(2, `IPSC_CST_C7, 1'b1);
    idle_t(3, `IPSC_CST_C7, 1'b1);
    tick(3);
    chk("last core l3", 8'(l3s), 8'h02);
    chk("deep flush", 8'(l3as), 8'h02);
    for (int t = 3; t >= 0; t--) wake_t(t, 1'b0, t > 1);
    rng <= 8'h03;
    io_t(0, 4, 1'b1);
    tick(2);
    chk("range miss", 8'(ccst[2:0]), 8'(`IPSC_CST_C0));
    redir <= 1'b0;
    io_t(0, 2, 1'b1);
    tick(4);
    ce <= 1'b0;
    io_t(0, 2, 1'b0);
    tick(2);
    ce <= 1'b1;
    tick(2);
    chk("pass left", 8'(pass_q), 8'h00);
    chk("ratio left", 8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
